// ### pkg/plane_add_pkg.sv
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Shared sizes, register map, field layout and opcode codes of the plane adder
package plane_add_pkg;
	// Array geometry: ES x ES elements, one bit each per plane
	localparam int ES          = 8;
	localparam int PLANE_W     = ES * ES;
	localparam int STORE_DEPTH = 32;
	localparam int SADDR_W     = 5;
	localparam int RSEL_W      = 3;
	localparam int NUM_REGS    = 5;
	localparam int OP_W        = 8;
	////////////////////////////////////////////////////////////////////////////
	// Byte offsets on the register bus
	localparam logic [7:0] OFS_INSTR     = 8'h00;
	localparam logic [7:0] OFS_STATUS    = 8'h04;
	localparam logic [7:0] OFS_BLK_BASE  = 8'h08;
	localparam logic [7:0] OFS_BLK_LIMIT = 8'h0C;
	localparam logic [7:0] OFS_CARRY_LO  = 8'h10;
	localparam logic [7:0] OFS_CARRY_HI  = 8'h14;
	localparam logic [7:0] OFS_ACC_LO    = 8'h18;
	localparam logic [7:0] OFS_ACC_HI    = 8'h1C;
	localparam logic [7:0] OFS_ACT_LO    = 8'h20;
	localparam logic [7:0] OFS_ACT_HI    = 8'h24;
	localparam logic [7:0] OFS_REG0      = 8'h28;
	localparam logic [7:0] OFS_SADDR     = 8'h40;
	localparam logic [7:0] OFS_SDATA_LO  = 8'h44;
	localparam logic [7:0] OFS_SDATA_HI  = 8'h48;
	localparam logic [7:0] OFS_EXEC_CNT  = 8'h4C;
	////////////////////////////////////////////////////////////////////////////
	// Instruction word and status fields
	localparam int INSTR_OP_LSB    = 0;
	localparam int INSTR_RSEL_LSB  = 8;
	localparam int INSTR_SADDR_LSB = 16;
	localparam int STATUS_ERR_BIT  = 0;
	// Reset values
	localparam logic [SADDR_W-1:0] RST_BLK_BASE  = 5'h00;
	localparam logic [SADDR_W-1:0] RST_BLK_LIMIT = 5'h1F;
	////////////////////////////////////////////////////////////////////////////
	// Opcode bit fields
	localparam int OP_SRC_LSB = 0;
	localparam int OP_INV_BIT = 3;
	localparam int OP_USE_C   = 4;
	localparam int OP_USE_A   = 5;
	localparam int OP_WSUM    = 6;
	localparam int OP_MOVE    = 7;
	// Third operand sources
	localparam logic [2:0] SRC_NONE  = 3'h0;
	localparam logic [2:0] SRC_ACT   = 3'h1;
	localparam logic [2:0] SRC_REG   = 3'h2;
	localparam logic [2:0] SRC_ORTH  = 3'h3;
	localparam logic [2:0] SRC_STORE = 3'h4;
	localparam logic [2:0] SRC_ONES  = 3'h5;
	////////////////////////////////////////////////////////////////////////////
	// Instruction codes
	localparam logic [7:0] OP_CARRY_OF_ACC_PLUS_STORE     = 8'h24;
	localparam logic [7:0] OP_CARRY_OF_ACC_PLUS_INV_STORE = 8'h2C;
	localparam logic [7:0] OP_MOVE_ACC_TO_CARRY           = 8'hA0;
	localparam logic [7:0] OP_ADD_CARRY_ACTIVITY          = 8'h51;
	localparam logic [7:0] OP_ADD_CARRY_INV_ACTIVITY      = 8'h59;
	localparam logic [7:0] OP_ADD_CARRY_ACC               = 8'h70;
	localparam logic [7:0] OP_ADD_CARRY_ACC_ACTIVITY      = 8'h71;
	localparam logic [7:0] OP_ADD_CARRY_ACC_INV_ACTIVITY  = 8'h79;
	localparam logic [7:0] OP_ADD_CARRY_ACC_REGPLANE      = 8'h72;
	localparam logic [7:0] OP_ADD_CARRY_ACC_INV_REGPLANE  = 8'h7A;
	localparam logic [7:0] OP_ADD_CARRY_ACC_ORTH_REGPLANE = 8'h73;
	localparam logic [7:0] OP_ADD_CARRY_ACC_INV_ORTH_REG  = 8'h7B;
	localparam logic [7:0] OP_ADD_CARRY_ACC_STORE         = 8'h74;
	localparam logic [7:0] OP_ADD_CARRY_ACC_INV_STORE     = 8'h7C;
	localparam logic [7:0] OP_ADD_CARRY_ACC_ONES          = 8'h75;
	localparam logic [7:0] OP_ADD_CARRY_REGPLANE          = 8'h52;
	localparam logic [7:0] OP_ADD_CARRY_INV_REGPLANE      = 8'h5A;
	localparam logic [7:0] OP_ADD_CARRY_ORTH_REGPLANE     = 8'h53;
	localparam logic [7:0] OP_ADD_CARRY_INV_ORTH_REGPLANE = 8'h5B;
	localparam logic [7:0] OP_ADD_CARRY_STORE             = 8'h54;
	localparam logic [7:0] OP_ADD_CARRY_INV_STORE         = 8'h5C;
	localparam logic [7:0] OP_ADD_ACC_ACTIVITY            = 8'h61;
	localparam logic [7:0] OP_ADD_ACC_INV_ACTIVITY        = 8'h69;
	localparam logic [7:0] OP_ADD_ACC_REGPLANE            = 8'h62;
	localparam logic [7:0] OP_ADD_ACC_INV_REGPLANE        = 8'h6A;
	localparam logic [7:0] OP_ADD_ACC_ORTH_REGPLANE       = 8'h63;
	localparam logic [7:0] OP_ADD_ACC_INV_ORTH_REGPLANE   = 8'h6B;
	localparam logic [7:0] OP_ADD_ACC_STORE               = 8'h64;
	localparam logic [7:0] OP_ADD_ACC_INV_STORE           = 8'h6C;
endpackage : plane_add_pkg
`default_nettype wire

// ### rtl/plane_bit_adder.sv
// Behaviour
// - Carry of accumulator plus store into carry
// - Inverted store variant uses complemented store bit
// - Store address outside block raises program error
// - Move copies accumulator into carry plane
// - Carry plus activity, optionally inverted activity
// - Carry plus accumulator, sum and carry stored
// - Carry, accumulator, activity full add
// - Carry, accumulator, register plane full add
// - Same with orthogonal register plane
// - Carry, accumulator, store plane full add
// - Carry, accumulator, constant ones full add
// - Carry plus register plane add
// - Carry plus orthogonal register plane add
// - Carry plus store plane add
// - Accumulator plus activity add
// - Accumulator plus register plane add
// - Accumulator plus orthogonal register plane add
// - Accumulator plus store plane add
// - Store address field from controller used
// - Register select field names source register
`timescale 1ns/1ps
`default_nettype none
module plane_bit_adder (
	input  wire logic        I_CLK,
	input  wire logic        I_RST_B,
	input  wire logic [7:0]  I_AVS_ADDRESS,
	input  wire logic        I_AVS_READ,
	input  wire logic        I_AVS_WRITE,
	input  wire logic [31:0] I_AVS_WRITEDATA,
	input  wire logic [3:0]  I_AVS_BYTEENABLE,
	output logic      [31:0] O_AVS_READDATA,
	output logic             O_AVS_WAITREQUEST,
	output logic             O_PROG_ERROR
);
	////////////////////////////////////////////////////////////////////////////
	// Declarations

	// Bus handshake
	logic        ack_reg;        // Answer cycle of the current access
	logic        req;            // Any access pending
	logic        wr_acc;         // Write taken at this edge
	logic [31:0] rdata_reg;      // Registered read data
	logic [31:0] rdata_next;     // Read mux
	logic [7:0]  word_addr;      // Address with byte bits cleared

	// Planes
	logic [plane_add_pkg::PLANE_W-1:0] carry_reg;   // Carry plane
	logic [plane_add_pkg::PLANE_W-1:0] acc_reg;     // Accumulator plane
	logic [plane_add_pkg::PLANE_W-1:0] act_reg;     // Activity plane
	logic [plane_add_pkg::PLANE_W-1:0] carry_next;  // Adder carry result
	logic [plane_add_pkg::PLANE_W-1:0] acc_next;    // Adder sum result
	logic [plane_add_pkg::PLANE_W-1:0] op_store;    // Addressed store plane
	logic [plane_add_pkg::PLANE_W-1:0] sw_store;    // Software-addressed plane

	// Control-unit and edge registers
	logic [31:0] cu_reg [plane_add_pkg::NUM_REGS];
	logic [plane_add_pkg::ES-1:0] reg_val;           // Selected register bits

	// Program block range and status
	logic [plane_add_pkg::SADDR_W-1:0] blk_base_reg;
	logic [plane_add_pkg::SADDR_W-1:0] blk_limit_reg;
	logic [plane_add_pkg::SADDR_W-1:0] sw_saddr_reg;  // Software store pointer
	logic [plane_add_pkg::PLANE_W-1:0] sdata_reg;     // Store write staging
	logic                              err_reg;       // Sticky program error
	logic [31:0]                       exec_cnt_reg;  // Executed instructions

	// Instruction fields
	logic [31:0]                       instr_word;
	logic [plane_add_pkg::OP_W-1:0]    opcode;
	logic [plane_add_pkg::RSEL_W-1:0]  register_select_field;
	logic [plane_add_pkg::SADDR_W-1:0] store_addr_field;
	logic                              uses_store;    // Opcode reads the store
	logic                              out_of_block;  // Address outside block
	logic                              issue;         // Instruction write taken
	logic                              exec;          // Instruction really runs
	logic                              sdata_hi_wr;   // Store commit strobe

	////////////////////////////////////////////////////////////////////////////
	// Byte lane merge

	// Apply byte enables to a 32-bit word
	function automatic logic [31:0] merge_be(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] be);
		logic [31:0] res;
		res = old_v;
		for (int k = 0; k < 4; k++) begin
			if (be[k]) begin
				res[k*8 +: 8] = new_v[k*8 +: 8];
			end
		end
		return res;
	endfunction : merge_be

	////////////////////////////////////////////////////////////////////////////
	// Bus slave handshake

	// Every access waits exactly one cycle
	assign req               = I_AVS_READ | I_AVS_WRITE;
	assign O_AVS_WAITREQUEST = req & ~ack_reg;
	assign wr_acc            = I_AVS_WRITE & ack_reg;
	assign word_addr         = {I_AVS_ADDRESS[7:2], 2'b00};
	assign O_AVS_READDATA    = rdata_reg;

	// Answer flag pulses high for one cycle per access
	always_ff @(posedge I_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= req & ~ack_reg;
		end
	end

	// Read data captured in the wait cycle
	always_ff @(posedge I_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			rdata_reg <= 32'h0000_0000;
		end else if (I_AVS_READ && !ack_reg) begin
			rdata_reg <= rdata_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Instruction decode

	assign instr_word            = I_AVS_WRITEDATA;
	assign opcode                = instr_word[plane_add_pkg::INSTR_OP_LSB +: plane_add_pkg::OP_W];
	assign register_select_field = instr_word[plane_add_pkg::INSTR_RSEL_LSB +: plane_add_pkg::RSEL_W];
	// Effective address already formed by the controller
	assign store_addr_field = instr_word[plane_add_pkg::INSTR_SADDR_LSB +: plane_add_pkg::SADDR_W];
	assign uses_store = (opcode[plane_add_pkg::OP_SRC_LSB +: 3] == plane_add_pkg::SRC_STORE) &&
		!opcode[plane_add_pkg::OP_MOVE];
	// Range check against the running block
	assign out_of_block = uses_store &&
		((store_addr_field < blk_base_reg) || (store_addr_field > blk_limit_reg));
	assign issue = wr_acc && (word_addr == plane_add_pkg::OFS_INSTR);
	// Faulting instruction leaves every plane alone
	assign exec        = issue && !out_of_block;
	assign sdata_hi_wr = wr_acc && (word_addr == plane_add_pkg::OFS_SDATA_HI);

	// Register feeding the register-derived plane
	always_comb begin
		if (register_select_field < 3'(plane_add_pkg::NUM_REGS)) begin
			reg_val = cu_reg[register_select_field][plane_add_pkg::ES-1:0];
		end else begin
			reg_val = '0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Datapath and store

	// Full adders across the whole array
	plane_operand_sel u_sel (
		.i_opcode     (opcode),
		.i_carry      (carry_reg),
		.i_acc        (acc_reg),
		.i_act        (act_reg),
		.i_store      (op_store),
		.i_reg_val    (reg_val),
		.o_carry_next (carry_next),
		.o_acc_next   (acc_next)
	);

	// Store planes, written by software through the staging pair
	plane_store_mem u_store (
		.i_clk     (I_CLK),
		.i_we      (sdata_hi_wr),
		.i_waddr   (sw_saddr_reg),
		.i_wdata   ({merge_be(sdata_reg[63:32], I_AVS_WRITEDATA, I_AVS_BYTEENABLE), sdata_reg[31:0]}),
		.i_raddr_a (store_addr_field),
		.i_raddr_b (sw_saddr_reg),
		.o_rdata_a (op_store),
		.o_rdata_b (sw_store)
	);

	////////////////////////////////////////////////////////////////////////////
	// Plane registers

	// Carry plane: instruction result or software load
	always_ff @(posedge I_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			carry_reg <= '0;
		end else if (exec) begin
			carry_reg <= carry_next;
		end else if (wr_acc && word_addr == plane_add_pkg::OFS_CARRY_LO) begin
			carry_reg[31:0] <= merge_be(carry_reg[31:0], I_AVS_WRITEDATA, I_AVS_BYTEENABLE);
		end else if (wr_acc && word_addr == plane_add_pkg::OFS_CARRY_HI) begin
			carry_reg[63:32] <= merge_be(carry_reg[63:32], I_AVS_WRITEDATA, I_AVS_BYTEENABLE);
		end
	end

	// Accumulator plane: sum result or software load
	always_ff @(posedge I_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			acc_reg <= '0;
		end else if (exec) begin
			acc_reg <= acc_next;
		end else if (wr_acc && word_addr == plane_add_pkg::OFS_ACC_LO) begin
			acc_reg[31:0] <= merge_be(acc_reg[31:0], I_AVS_WRITEDATA, I_AVS_BYTEENABLE);
		end else if (wr_acc && word_addr == plane_add_pkg::OFS_ACC_HI) begin
			acc_reg[63:32] <= merge_be(acc_reg[63:32], I_AVS_WRITEDATA, I_AVS_BYTEENABLE);
		end
	end

	// Activity plane: software only, adds never write it
	always_ff @(posedge I_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			act_reg <= '0;
		end else if (wr_acc && word_addr == plane_add_pkg::OFS_ACT_LO) begin
			act_reg[31:0] <= merge_be(act_reg[31:0], I_AVS_WRITEDATA, I_AVS_BYTEENABLE);
		end else if (wr_acc && word_addr == plane_add_pkg::OFS_ACT_HI) begin
			act_reg[63:32] <= merge_be(act_reg[63:32], I_AVS_WRITEDATA, I_AVS_BYTEENABLE);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Control-unit and edge registers

	// One register per slot, written only by software
	for (genvar r = 0; r < plane_add_pkg::NUM_REGS; r++) begin : g_cureg
		always_ff @(posedge I_CLK or negedge I_RST_B) begin
			if (!I_RST_B) begin
				cu_reg[r] <= 32'h0000_0000;
			end else if (wr_acc && word_addr == 8'(plane_add_pkg::OFS_REG0 + 8'(4 * r))) begin
				cu_reg[r] <= merge_be(cu_reg[r], I_AVS_WRITEDATA, I_AVS_BYTEENABLE);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Block range, store pointer and staging

	// Program block bounds
	always_ff @(posedge I_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			blk_base_reg  <= plane_add_pkg::RST_BLK_BASE;
			blk_limit_reg <= plane_add_pkg::RST_BLK_LIMIT;
		end else if (wr_acc && word_addr == plane_add_pkg::OFS_BLK_BASE) begin
			blk_base_reg <= I_AVS_WRITEDATA[plane_add_pkg::SADDR_W-1:0];
		end else if (wr_acc && word_addr == plane_add_pkg::OFS_BLK_LIMIT) begin
			blk_limit_reg <= I_AVS_WRITEDATA[plane_add_pkg::SADDR_W-1:0];
		end
	end

	// Software store pointer
	always_ff @(posedge I_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			sw_saddr_reg <= '0;
		end else if (wr_acc && word_addr == plane_add_pkg::OFS_SADDR) begin
			sw_saddr_reg <= I_AVS_WRITEDATA[plane_add_pkg::SADDR_W-1:0];
		end
	end

	// Low half staged; high-half write commits the whole plane
	always_ff @(posedge I_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			sdata_reg <= '0;
		end else if (wr_acc && word_addr == plane_add_pkg::OFS_SDATA_LO) begin
			sdata_reg[31:0] <= merge_be(sdata_reg[31:0], I_AVS_WRITEDATA, I_AVS_BYTEENABLE);
		end else if (sdata_hi_wr) begin
			sdata_reg[63:32] <= merge_be(sdata_reg[63:32], I_AVS_WRITEDATA, I_AVS_BYTEENABLE);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Status

	// Sticky error: a new fault wins over a clear in the same write
	always_ff @(posedge I_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			err_reg <= 1'b0;
		end else if (issue && out_of_block) begin
			err_reg <= 1'b1;
		end else if (wr_acc && word_addr == plane_add_pkg::OFS_STATUS &&
			I_AVS_BYTEENABLE[0] && I_AVS_WRITEDATA[plane_add_pkg::STATUS_ERR_BIT]) begin
			err_reg <= 1'b0;
		end
	end

	assign O_PROG_ERROR = err_reg;

	// Count of instructions that ran
	always_ff @(posedge I_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			exec_cnt_reg <= 32'h0000_0000;
		end else if (exec) begin
			exec_cnt_reg <= exec_cnt_reg + 32'h0000_0001;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read mux

	// Unmapped offsets read as zero
	always_comb begin
		rdata_next = 32'h0000_0000;
		case (word_addr)
			plane_add_pkg::OFS_STATUS:    rdata_next[plane_add_pkg::STATUS_ERR_BIT] = err_reg;
			plane_add_pkg::OFS_BLK_BASE:  rdata_next = 32'(blk_base_reg);
			plane_add_pkg::OFS_BLK_LIMIT: rdata_next = 32'(blk_limit_reg);
			plane_add_pkg::OFS_CARRY_LO:  rdata_next = carry_reg[31:0];
			plane_add_pkg::OFS_CARRY_HI:  rdata_next = carry_reg[63:32];
			plane_add_pkg::OFS_ACC_LO:    rdata_next = acc_reg[31:0];
			plane_add_pkg::OFS_ACC_HI:    rdata_next = acc_reg[63:32];
			plane_add_pkg::OFS_ACT_LO:    rdata_next = act_reg[31:0];
			plane_add_pkg::OFS_ACT_HI:    rdata_next = act_reg[63:32];
			plane_add_pkg::OFS_SADDR:     rdata_next = 32'(sw_saddr_reg);
			plane_add_pkg::OFS_SDATA_LO:  rdata_next = sw_store[31:0];
			plane_add_pkg::OFS_SDATA_HI:  rdata_next = sw_store[63:32];
			plane_add_pkg::OFS_EXEC_CNT:  rdata_next = exec_cnt_reg;
			default: begin
				// Control-unit register window
				for (int r = 0; r < plane_add_pkg::NUM_REGS; r++) begin
					if (word_addr == 8'(plane_add_pkg::OFS_REG0 + 8'(4 * r))) begin
						rdata_next = cu_reg[r];
					end
				end
			end
		endcase
	end
endmodule : plane_bit_adder
`default_nettype wire

// ### rtl/plane_operand_sel.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Per-element operand choice and full adder, all elements at once
module plane_operand_sel (
	input  wire logic [plane_add_pkg::OP_W-1:0]    i_opcode,
	input  wire logic [plane_add_pkg::PLANE_W-1:0] i_carry,
	input  wire logic [plane_add_pkg::PLANE_W-1:0] i_acc,
	input  wire logic [plane_add_pkg::PLANE_W-1:0] i_act,
	input  wire logic [plane_add_pkg::PLANE_W-1:0] i_store,
	input  wire logic [plane_add_pkg::ES-1:0]      i_reg_val,
	output logic      [plane_add_pkg::PLANE_W-1:0] o_carry_next,
	output logic      [plane_add_pkg::PLANE_W-1:0] o_acc_next
);
	// Decoded opcode fields
	logic [2:0] src;
	logic       inv;
	logic       use_c;
	logic       use_a;
	logic       wsum;
	logic       move;

	assign src   = i_opcode[plane_add_pkg::OP_SRC_LSB +: 3];
	assign inv   = i_opcode[plane_add_pkg::OP_INV_BIT];
	assign use_c = i_opcode[plane_add_pkg::OP_USE_C];
	assign use_a = i_opcode[plane_add_pkg::OP_USE_A];
	assign wsum  = i_opcode[plane_add_pkg::OP_WSUM];
	assign move  = i_opcode[plane_add_pkg::OP_MOVE];

	// One full adder per element, fed from pre-instruction planes
	for (genvar e = 0; e < plane_add_pkg::PLANE_W; e++) begin : g_elem
		logic t_raw;
		logic t;
		logic a;
		logic b;
		logic s;
		logic cy;
		// Third operand: activity, row- or column-broadcast register plane, store plane or ones
		always_comb begin
			case (src)
				plane_add_pkg::SRC_ACT:   t_raw = i_act[e];
				plane_add_pkg::SRC_REG:   t_raw = i_reg_val[e % plane_add_pkg::ES];
				plane_add_pkg::SRC_ORTH:  t_raw = i_reg_val[e / plane_add_pkg::ES];
				plane_add_pkg::SRC_STORE: t_raw = i_store[e];
				plane_add_pkg::SRC_ONES:  t_raw = 1'b1;
				default:                  t_raw = 1'b0;
			endcase
		end
		assign t  = (src == plane_add_pkg::SRC_NONE) ? 1'b0 : (t_raw ^ inv);
		assign a  = use_c & i_carry[e];
		assign b  = use_a & i_acc[e];
		assign s  = a ^ b ^ t;
		assign cy = (a & b) | (a & t) | (b & t);
		// Move copies the accumulator; adds keep the majority
		assign o_carry_next[e] = move ? i_acc[e] : cy;
		// Sum kept only when the opcode asks for it
		assign o_acc_next[e] = wsum ? s : i_acc[e];
	end
endmodule : plane_operand_sel
`default_nettype wire

// ### rtl/plane_store_mem.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Store of bit planes: one write port, two combinational read ports
module plane_store_mem (
	input  wire logic                                 i_clk,
	input  wire logic                                 i_we,
	input  wire logic [plane_add_pkg::SADDR_W-1:0]    i_waddr,
	input  wire logic [plane_add_pkg::PLANE_W-1:0]    i_wdata,
	input  wire logic [plane_add_pkg::SADDR_W-1:0]    i_raddr_a,
	input  wire logic [plane_add_pkg::SADDR_W-1:0]    i_raddr_b,
	output logic      [plane_add_pkg::PLANE_W-1:0]    o_rdata_a,
	output logic      [plane_add_pkg::PLANE_W-1:0]    o_rdata_b
);
	// Plane storage, no reset: contents undefined until written
	logic [plane_add_pkg::PLANE_W-1:0] mem [plane_add_pkg::STORE_DEPTH];

	// Write port
	always_ff @(posedge i_clk) begin
		if (i_we) begin
			mem[i_waddr] <= i_wdata;
		end
	end

	// Operand read and software read
	assign o_rdata_a = mem[i_raddr_a];
	assign o_rdata_b = mem[i_raddr_b];
endmodule : plane_store_mem
`default_nettype wire

// ### verif/mcu_model.sv
`timescale 1ns/1ps
`default_nettype none
// Control unit stand-in: issues bus cycles and forms instruction words
module mcu_model (
	input  wire logic        i_clk,
	input  wire logic        i_wait,
	input  wire logic [31:0] i_rdata,
	output logic      [7:0]  o_addr,
	output logic             o_rd,
	output logic             o_wr,
	output logic      [31:0] o_wdata
);
	initial begin
		o_addr = 8'h00;
		o_rd = 1'b0;
		o_wr = 1'b0;
		o_wdata = 32'h0;
	end
	// Write held until the slave stops stalling
	task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clk);
		o_addr <= a;
		o_wdata <= d;
		o_wr <= 1'b1;
		do @(posedge i_clk); while (i_wait);
		o_wr <= 1'b0;
	endtask : bus_wr
	// Read held likewise, data taken at the accepting edge
	task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge i_clk);
		o_addr <= a;
		o_rd <= 1'b1;
		do @(posedge i_clk); while (i_wait);
		d = i_rdata;
		o_rd <= 1'b0;
	endtask : bus_rd
	// Effective store address is base plane plus offset
	task automatic instr(input logic [7:0] op, input logic [2:0] rs, input logic [4:0] pl, input logic [4:0] ofs);
		bus_wr(8'h00, {11'h000, 5'(pl + ofs), 5'h00, rs, op});
	endtask : instr
endmodule : mcu_model
`default_nettype wire

// ### verif/plane_bit_adder_sva.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Bus timing and program error watcher
module plane_bit_adder_sva (
	input wire logic        I_CLK,
	input wire logic        I_RST_B,
	input wire logic [7:0]  I_AVS_ADDRESS,
	input wire logic        I_AVS_READ,
	input wire logic        I_AVS_WRITE,
	input wire logic [31:0] I_AVS_WRITEDATA,
	input wire logic [31:0] O_AVS_READDATA,
	input wire logic        O_AVS_WAITREQUEST,
	input wire logic        O_PROG_ERROR
);
	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (!I_RST_B);
	logic       wr_ok, rd_ok, bad_op, err_clr;
	logic [4:0] sa, base_reg, limit_reg;
	assign wr_ok = I_AVS_WRITE && !O_AVS_WAITREQUEST;
	assign rd_ok = I_AVS_READ && !O_AVS_WAITREQUEST;
	assign sa = I_AVS_WRITEDATA[20:16];
	// Store instruction accepted outside the program block
	assign bad_op = wr_ok && I_AVS_ADDRESS[7:2] == 6'h00 && I_AVS_WRITEDATA[2:0] == 3'h4 && !I_AVS_WRITEDATA[7]
		&& (sa < base_reg || sa > limit_reg);
	assign err_clr = wr_ok && I_AVS_ADDRESS[7:2] == 6'h01 && I_AVS_WRITEDATA[0];
	// Shadow of the block bounds
	always_ff @(posedge I_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			base_reg <= 5'h00;
			limit_reg <= 5'h1F;
		end else if (wr_ok && I_AVS_ADDRESS[7:2] == 6'h02) begin
			base_reg <= I_AVS_WRITEDATA[4:0];
		end else if (wr_ok && I_AVS_ADDRESS[7:2] == 6'h03) begin
			limit_reg <= I_AVS_WRITEDATA[4:0];
		end
	end
	sequence stall_s;
		(I_AVS_READ || I_AVS_WRITE) && O_AVS_WAITREQUEST;
	endsequence
	wait_first_a: assert property ($rose(I_AVS_READ || I_AVS_WRITE) |-> O_AVS_WAITREQUEST)
		else $error("new request not stalled");
	wait_once_a: assert property (stall_s |=> !O_AVS_WAITREQUEST) else $error("stall too long");
	idle_nowait_a: assert property (!(I_AVS_READ || I_AVS_WRITE) |-> !O_AVS_WAITREQUEST) else $error("idle stall");
	err_raise_a: assert property (bad_op |=> O_PROG_ERROR) else $error("error not raised");
	err_hold_a: assert property (O_PROG_ERROR && !err_clr |=> O_PROG_ERROR) else $error("error lost");
	err_clear_a: assert property (err_clr && !bad_op |=> !O_PROG_ERROR) else $error("error not cleared");
	err_cause_a: assert property ($rose(O_PROG_ERROR) |-> $past(bad_op)) else $error("error unprompted");
	unmapped_zero_a: assert property (rd_ok && I_AVS_ADDRESS >= 8'h50 |-> O_AVS_READDATA == 32'h0)
		else $error("unmapped read not zero");
	limit_read_a: assert property (rd_ok && I_AVS_ADDRESS == 8'h0C |-> O_AVS_READDATA[4:0] == limit_reg)
		else $error("limit readback wrong");
endmodule : plane_bit_adder_sva
bind plane_bit_adder plane_bit_adder_sva u_plane_bit_adder_sva (.I_CLK(I_CLK), .I_RST_B(I_RST_B),
	.I_AVS_ADDRESS(I_AVS_ADDRESS), .I_AVS_READ(I_AVS_READ), .I_AVS_WRITE(I_AVS_WRITE),
	.I_AVS_WRITEDATA(I_AVS_WRITEDATA), .O_AVS_READDATA(O_AVS_READDATA),
	.O_AVS_WAITREQUEST(O_AVS_WAITREQUEST), .O_PROG_ERROR(O_PROG_ERROR));
`default_nettype wire

// ### verif/plane_bit_adder_tb.sv
`timescale 1ns/1ps
`default_nettype none
module plane_bit_adder_tb;
	logic        clk = 1'b0;
	logic        rst_b = 1'b0;
	logic [7:0]  addr;
	logic        rd, wr, wait_req, err;
	logic [31:0] wdata, rdata, q;
	logic [63:0] c, a, t, s;
	logic [7:0]  rg [5] = '{8'h0F, 8'h5A, 8'hC3, 8'h81, 8'h3C};
	int          fails = 0, tests_run = 0, cycles = 0;
	// Rows: register select in the top digit, instruction code below
	logic [10:0] rows [29] = '{11'h024, 11'h02C, 11'h0A0, 11'h051, 11'h059, 11'h070, 11'h071, 11'h079,
		11'h172, 11'h47A, 11'h273, 11'h67B, 11'h074, 11'h07C, 11'h075, 11'h352, 11'h75A, 11'h453, 11'h15B,
		11'h054, 11'h05C, 11'h061, 11'h069, 11'h262, 11'h36A, 11'h063, 11'h46B, 11'h064, 11'h06C};
	always #5 clk = ~clk;
	plane_bit_adder u_plane_bit_adder (.I_CLK(clk), .I_RST_B(rst_b), .I_AVS_ADDRESS(addr), .I_AVS_READ(rd),
		.I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wdata), .I_AVS_BYTEENABLE(4'hF), .O_AVS_READDATA(rdata),
		.O_AVS_WAITREQUEST(wait_req), .O_PROG_ERROR(err));
	mcu_model u_mcu_model (.i_clk(clk), .i_wait(wait_req), .i_rdata(rdata), .o_addr(addr), .o_rd(rd),
		.o_wr(wr), .o_wdata(wdata));
	task automatic wrap_up;
		if (fails == 0 && tests_run > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : wrap_up
	task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] got);
		tests_run++;
		if (got !== e) begin
			fails++;
			$display("wrong value %s expected %h seen %h", nm, e, got);
		end
	endtask : chk
	task automatic chk_plane(input string nm, input logic [7:0] lo, input logic [63:0] e);
		logic [31:0] l, h;
		u_mcu_model.bus_rd(lo, l);
		u_mcu_model.bus_rd(lo + 8'h04, h);
		chk(nm, e, {h, l});
	endtask : chk_plane
	task automatic ld(input logic [7:0] lo, input logic [63:0] p);
		u_mcu_model.bus_wr(lo, p[31:0]);
		u_mcu_model.bus_wr(lo + 8'h04, p[63:32]);
	endtask : ld
	task automatic st_chk(input logic e);
		u_mcu_model.bus_rd(8'h04, q);
		chk("error flag and pin", {62'h0, e, e}, {62'h0, q[0], err});
	endtask : st_chk
	// Expected effect of one instruction on the shadow planes
	function automatic void step(input logic [10:0] r);
		logic [63:0] x, y, z;
		logic [7:0]  g;
		g = (r[10:8] < 3'h5) ? rg[r[10:8]] : 8'h00;
		x = r[4] ? c : 64'h0;
		y = r[5] ? a : 64'h0;
		z = 64'h0;
		case (r[2:0])
			3'h1: z = t;
			3'h2: z = {8{g}};
			3'h3: for (int k = 0; k < 8; k++) z[8*k +: 8] = {8{g[k]}};
			3'h4: z = s;
			3'h5: z = ~64'h0;
			default: z = 64'h0;
		endcase
		if (r[3]) z = ~z;
		if (r[7]) c = a;
		else begin
			if (r[6]) a = x ^ y ^ z;
			c = (x & y) | (x & z) | (y & z);
		end
	endfunction : step
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			wrap_up;
		end
	end
	initial begin
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
		u_mcu_model.bus_rd(8'h0C, q);
		chk("block limit", 64'h1F, {32'h0, q});
		for (int i = 0; i < 5; i++) u_mcu_model.bus_wr(8'h28 + 8'(4 * i), {24'h0, rg[i]});
		t = 64'h0123_4567_89AB_CDEF;
		s = 64'hF0F0_3C3C_AA55_9966;
		ld(8'h20, t);
		u_mcu_model.bus_wr(8'h40, 32'h3);
		ld(8'h44, s);
		foreach (rows[i]) begin
			c = 64'hFF00_FF00_F0F0_CCAA;
			a = 64'h0FF0_3C3C_9999_6565;
			ld(8'h10, c);
			ld(8'h18, a);
			u_mcu_model.instr(rows[i][7:0], rows[i][10:8], 5'h01, 5'h02);
			step(rows[i]);
			chk_plane("carry plane", 8'h10, c);
			chk_plane("acc plane", 8'h18, a);
			chk_plane("activity plane", 8'h20, t);
		end
		// Back to back adds each use the previous result
		u_mcu_model.instr(8'h75, 3'h0, 5'h00, 5'h00);
		u_mcu_model.instr(8'h75, 3'h0, 5'h00, 5'h00);
		step(11'h075);
		step(11'h075);
		chk_plane("chained acc", 8'h18, a);
		// Block of one plane: below, above, then exactly on it
		u_mcu_model.bus_wr(8'h08, 32'h3);
		u_mcu_model.bus_wr(8'h0C, 32'h3);
		u_mcu_model.instr(8'h74, 3'h0, 5'h00, 5'h02);
		st_chk(1'b1);
		chk_plane("refused carry", 8'h10, c);
		u_mcu_model.bus_wr(8'h04, 32'h1);
		u_mcu_model.instr(8'h74, 3'h0, 5'h02, 5'h02);
		st_chk(1'b1);
		u_mcu_model.bus_wr(8'h04, 32'h1);
		u_mcu_model.instr(8'h74, 3'h0, 5'h01, 5'h02);
		step(11'h074);
		st_chk(1'b0);
		chk_plane("in block carry", 8'h10, c);
		u_mcu_model.bus_rd(8'h4C, q);
		chk("executed count", 64'h20, {32'h0, q});
		u_mcu_model.bus_rd(8'h50, q);
		chk("unmapped read", 64'h0, {32'h0, q});
		wrap_up;
	end
endmodule : plane_bit_adder_tb
`default_nettype wire
